// >>> src/rioc_port.sv
`timescale 1ns/1ps
`default_nettype none
module rioc_port (
    input  wire logic                          clk_i,             // 50 MHz system clock
    input  wire logic                          reset_n_i,         // async reset, active low
    input  wire logic                          clk_en_i,          // freezes state when low
    input  wire logic [rioc_pkg::IO_WIDTH-1:0] remote_in_i,       // connector input pins
    input  wire logic                          console_select_i,  // io_remote_console chosen
    input  wire logic                          teach_mode_i,      // teach mode selected
    input  wire logic                          auto_mode_i,       // auto mode selected
    input  wire logic                          estop_i,           // emergency stop state
    input  wire logic                          safeguard_open_i,  // safeguard open
    input  wire logic                          enable_cond_i,     // enable condition
    input  wire logic                          home_pos_i,        // manipulator at home
    input  wire logic                          error_event_i,     // controller error pulse
    input  wire logic                          error_cancel_i,    // error cause removed
    input  wire logic                          stopped_i,         // robot motion stopped
    input  wire logic                          done_i,            // program/command finished
    output var  logic [rioc_pkg::IO_WIDTH-1:0] remote_out_o,      // connector output pins
    output var  logic                          cmd_reset_o,       // reset controller pulse
    output var  logic                          cmd_start_o,       // start program pulse
    output var  logic                          cmd_resume_o,      // resume program pulse
    output var  logic                          cmd_pause_o,       // pause program pulse
    output var  logic                          cmd_home_o,        // move home pulse
    output var  logic                          cmd_cal_o,         // calibration pulse
    output var  logic [rioc_pkg::PROG_WIDTH-1:0] program_number_command_o, // loaded program
    output var  logic                          motor_power_o      // motor power on
);
    rioc_edge_if edges ();

    rioc_input_sync u_sync (
        .clk_i     (clk_i),
        .reset_n_i (reset_n_i),
        .clk_en_i  (clk_en_i),
        .pins_i    (remote_in_i),
        .edges     (edges.src)
    );

    rioc_pkg::rioc_state_type state_reg;
    rioc_pkg::rioc_state_type state_next;
    logic [rioc_pkg::PROG_WIDTH-1:0] prog_next;
    logic [rioc_pkg::IO_WIDTH-1:0]   out_next;
    logic [rioc_pkg::IO_WIDTH-1:0]   acc_rise;
    logic motor_next;
    logic error_reg;
    logic error_next;
    logic reset_next;
    logic start_next;
    logic resume_next;
    logic pause_next;
    logic home_next;
    logic cal_next;
    logic busy;

    // io_remote_console must be selected and teach mode must be off
    assign acc_rise = (console_select_i && !teach_mode_i) ? edges.rise : rioc_pkg::IO_ZERO;

    always_comb
    begin
        state_next  = state_reg;
        prog_next   = program_number_command_o;
        motor_next  = motor_power_o;
        error_next  = error_reg;
        reset_next  = 1'b0;
        start_next  = 1'b0;
        resume_next = 1'b0;
        pause_next  = 1'b0;
        home_next   = 1'b0;
        cal_next    = 1'b0;
        if (acc_rise[rioc_pkg::IN_RESET])
        begin
            state_next = rioc_pkg::ST_RESET;
            reset_next = 1'b1;
            if (error_cancel_i)
                error_next = 1'b0;
        end
        else
        begin
            case (state_reg)
                rioc_pkg::ST_RESET:
                begin
                    if (acc_rise[rioc_pkg::IN_START])
                    begin
                        // program number sampled at start
                        prog_next  = edges.level[rioc_pkg::IN_PROG_LSB +: rioc_pkg::PROG_WIDTH];
                        state_next = rioc_pkg::ST_RUN;
                        start_next = 1'b1;
                    end
                    else if (acc_rise[rioc_pkg::IN_HOME])
                    begin
                        state_next = rioc_pkg::ST_HOMING;
                        home_next  = 1'b1;
                    end
                    else if (acc_rise[rioc_pkg::IN_CAL])
                    begin
                        state_next = rioc_pkg::ST_CAL;
                        cal_next   = 1'b1;
                    end
                end
                rioc_pkg::ST_RUN:
                begin
                    if (acc_rise[rioc_pkg::IN_PAUSE])
                    begin
                        state_next = rioc_pkg::ST_PAUSING;
                        pause_next = 1'b1;
                    end
                    else if (done_i)
                        state_next = rioc_pkg::ST_RESET;
                end
                rioc_pkg::ST_PAUSING:
                begin
                    if (stopped_i)
                        state_next = rioc_pkg::ST_PAUSED;
                end
                rioc_pkg::ST_PAUSED:
                begin
                    if (acc_rise[rioc_pkg::IN_START])
                    begin
                        state_next  = rioc_pkg::ST_RUN;
                        resume_next = 1'b1;
                    end
                end
                rioc_pkg::ST_HOMING,
                rioc_pkg::ST_CAL:
                begin
                    if (done_i)
                        state_next = rioc_pkg::ST_RESET;
                end
                default:
                    state_next = rioc_pkg::ST_RESET;
            endcase
            // motor on only from reset state; off is honoured unless reset rises in the same cycle, and wins
            if (acc_rise[rioc_pkg::IN_MOTOR_ON] && state_reg == rioc_pkg::ST_RESET)
                motor_next = 1'b1;
            if (acc_rise[rioc_pkg::IN_MOTOR_OFF])
                motor_next = 1'b0;
        end
        // a new error wins over a clear in the same cycle
        if (error_event_i)
            error_next = 1'b1;
    end

    assign busy = (state_reg == rioc_pkg::ST_RUN) || (state_reg == rioc_pkg::ST_PAUSING) ||
                  (state_reg == rioc_pkg::ST_HOMING) || (state_reg == rioc_pkg::ST_CAL);

    always_comb
    begin
        out_next                                                     = rioc_pkg::IO_ZERO;
        out_next[rioc_pkg::OUT_RESET]                                = (state_reg == rioc_pkg::ST_RESET);
        out_next[rioc_pkg::OUT_PAUSED]                               = (state_reg == rioc_pkg::ST_PAUSED);
        out_next[rioc_pkg::OUT_RUNNING]                              = busy;
        out_next[rioc_pkg::OUT_HOME]                                 = home_pos_i;
        out_next[rioc_pkg::OUT_PROG_LSB +: rioc_pkg::PROG_WIDTH]     = program_number_command_o;
        out_next[rioc_pkg::OUT_CAL]                                  = (state_reg == rioc_pkg::ST_CAL);
        out_next[rioc_pkg::OUT_MOTOR]                                = motor_power_o;
        out_next[rioc_pkg::OUT_ERROR]                                = error_reg;
        out_next[rioc_pkg::OUT_ESTOP]                                = estop_i;
        out_next[rioc_pkg::OUT_SAFEGUARD]                            = safeguard_open_i;
        out_next[rioc_pkg::OUT_AUTO]                                 = auto_mode_i;
        out_next[rioc_pkg::OUT_TEACH]                                = teach_mode_i;
        out_next[rioc_pkg::OUT_ENABLE]                               = enable_cond_i;
    end

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            state_reg                <= rioc_pkg::ST_RESET;
            program_number_command_o <= rioc_pkg::PROG_ZERO;
            motor_power_o            <= 1'b0;
            error_reg                <= 1'b0;
            remote_out_o             <= rioc_pkg::IO_ZERO;
            cmd_reset_o              <= 1'b0;
            cmd_start_o              <= 1'b0;
            cmd_resume_o             <= 1'b0;
            cmd_pause_o              <= 1'b0;
            cmd_home_o               <= 1'b0;
            cmd_cal_o                <= 1'b0;
        end
        else if (clk_en_i)
        begin
            state_reg                <= state_next;
            program_number_command_o <= prog_next;
            motor_power_o            <= motor_next;
            error_reg                <= error_next;
            remote_out_o             <= out_next;
            cmd_reset_o              <= reset_next;
            cmd_start_o              <= start_next;
            cmd_resume_o             <= resume_next;
            cmd_pause_o              <= pause_next;
            cmd_home_o               <= home_next;
            cmd_cal_o                <= cal_next;
        end
    end

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!reset_n_i);

    chk_prog_load: assert property (
        (clk_en_i && state_reg == rioc_pkg::ST_RESET && acc_rise[rioc_pkg::IN_START] && !acc_rise[rioc_pkg::IN_RESET])
        |=> program_number_command_o == $past(edges.level[rioc_pkg::IN_PROG_LSB +: rioc_pkg::PROG_WIDTH]) && cmd_start_o)
        else $error("program number not loaded at start");
    chk_reset_cmd: assert property (
        (clk_en_i && acc_rise[rioc_pkg::IN_RESET]) |=> state_reg == rioc_pkg::ST_RESET && cmd_reset_o)
        else $error("reset input did not reset controller");
    chk_pause_enter: assert property (
        (clk_en_i && state_reg == rioc_pkg::ST_RUN && acc_rise[rioc_pkg::IN_PAUSE] && !acc_rise[rioc_pkg::IN_RESET])
        |=> state_reg == rioc_pkg::ST_PAUSING && cmd_pause_o)
        else $error("pause input did not suspend program");
    chk_paused_flag: assert property (
        clk_en_i |=> remote_out_o[rioc_pkg::OUT_PAUSED] == ($past(state_reg) == rioc_pkg::ST_PAUSED))
        else $error("paused output out of step with state");
    chk_reset_flag: assert property (
        clk_en_i |=> remote_out_o[rioc_pkg::OUT_RESET] == ($past(state_reg) == rioc_pkg::ST_RESET))
        else $error("reset-state output out of step with state");
    chk_teach_ignore: assert property (
        teach_mode_i |-> acc_rise == rioc_pkg::IO_ZERO)
        else $error("remote input accepted in teach mode");
    chk_error_clear: assert property (
        (clk_en_i && acc_rise[rioc_pkg::IN_RESET] && error_cancel_i && !error_event_i) |=> ##1 !remote_out_o[rioc_pkg::OUT_ERROR])
        else $error("error output not dropped by reset");
    chk_motor_on: assert property (
        (clk_en_i && state_reg == rioc_pkg::ST_RESET && acc_rise[rioc_pkg::IN_MOTOR_ON]
         && !acc_rise[rioc_pkg::IN_MOTOR_OFF] && !acc_rise[rioc_pkg::IN_RESET]) |=> motor_power_o)
        else $error("motor power on not applied");
    chk_motor_off: assert property (
        (clk_en_i && acc_rise[rioc_pkg::IN_MOTOR_OFF] && !acc_rise[rioc_pkg::IN_RESET]) |=> !motor_power_o)
        else $error("motor power off not applied");
endmodule
`default_nettype wire

// >>> src/rioc_pkg.sv
package rioc_pkg;
    localparam int unsigned IO_WIDTH   = 16;
    localparam int unsigned PROG_WIDTH = 4;

    // input bit positions
    localparam int unsigned IN_RESET     = 0;
    localparam int unsigned IN_PAUSE     = 1;
    localparam int unsigned IN_START     = 2;
    localparam int unsigned IN_HOME      = 3;
    localparam int unsigned IN_PROG_LSB  = 4;
    localparam int unsigned IN_CAL       = 8;
    localparam int unsigned IN_MOTOR_ON  = 9;
    localparam int unsigned IN_MOTOR_OFF = 10;

    // output bit positions
    localparam int unsigned OUT_RESET     = 0;
    localparam int unsigned OUT_PAUSED    = 1;
    localparam int unsigned OUT_RUNNING   = 2;
    localparam int unsigned OUT_HOME      = 3;
    localparam int unsigned OUT_PROG_LSB  = 4;
    localparam int unsigned OUT_CAL       = 8;
    localparam int unsigned OUT_MOTOR     = 9;
    localparam int unsigned OUT_ERROR     = 10;
    localparam int unsigned OUT_ESTOP     = 11;
    localparam int unsigned OUT_SAFEGUARD = 12;
    localparam int unsigned OUT_AUTO      = 13;
    localparam int unsigned OUT_TEACH     = 14;
    localparam int unsigned OUT_ENABLE    = 15;

    localparam logic [IO_WIDTH-1:0]   IO_ZERO   = 16'h0000;
    localparam logic [PROG_WIDTH-1:0] PROG_ZERO = 4'h0;

    typedef enum logic [2:0] {
        ST_RESET,
        ST_RUN,
        ST_PAUSING,
        ST_PAUSED,
        ST_HOMING,
        ST_CAL
    } rioc_state_type;
endpackage

// >>> src/rioc_edge_if.sv
`timescale 1ns/1ps
`default_nettype none
interface rioc_edge_if;
    logic [rioc_pkg::IO_WIDTH-1:0] level;
    logic [rioc_pkg::IO_WIDTH-1:0] rise;
    modport src (output level, output rise);
    modport dst (input level, input rise);
endinterface
`default_nettype wire

// >>> src/rioc_input_sync.sv
`timescale 1ns/1ps
`default_nettype none
module rioc_input_sync (
    input  wire logic                          clk_i,      // system clock
    input  wire logic                          reset_n_i,  // async reset, active low
    input  wire logic                          clk_en_i,   // freezes state when low
    input  wire logic [rioc_pkg::IO_WIDTH-1:0] pins_i,     // raw connector inputs
    rioc_edge_if.src                           edges       // synced levels and rises
);
    logic [rioc_pkg::IO_WIDTH-1:0] meta_reg;
    logic [rioc_pkg::IO_WIDTH-1:0] meta_next;
    logic [rioc_pkg::IO_WIDTH-1:0] sync_reg;
    logic [rioc_pkg::IO_WIDTH-1:0] sync_next;
    logic [rioc_pkg::IO_WIDTH-1:0] last_reg;
    logic [rioc_pkg::IO_WIDTH-1:0] last_next;

    always_comb
    begin
        meta_next = meta_reg;
        sync_next = sync_reg;
        last_next = last_reg;
        if (clk_en_i)
        begin
            meta_next = pins_i;
            sync_next = meta_reg;
            last_next = sync_reg;
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            meta_reg <= rioc_pkg::IO_ZERO;
            sync_reg <= rioc_pkg::IO_ZERO;
            last_reg <= rioc_pkg::IO_ZERO;
        end
        else
        begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
            last_reg <= last_next;
        end
    end

    // a held input gives one rise only
    assign edges.level = sync_reg;
    assign edges.rise  = sync_reg & ~last_reg;

    chk_rise_once: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (clk_en_i && edges.rise != rioc_pkg::IO_ZERO) |=> ((edges.rise & $past(edges.rise)) == rioc_pkg::IO_ZERO))
        else $error("input rise seen on two cycles running");
endmodule
`default_nettype wire

// >>> tb/rioc_seq_model.sv
`timescale 1ns/1ps
`default_nettype none
module rioc_seq_model (
    input  wire logic                          clk_i,     // system clock
    input  wire logic [rioc_pkg::IO_WIDTH-1:0] status_i,  // device status outputs
    output var  logic [rioc_pkg::IO_WIDTH-1:0] pins_o,    // command pins
    output var  logic                          late_o     // a wait ran out
);
    initial pins_o = rioc_pkg::IO_ZERO;
    initial late_o = 1'b0;
    // ------------------------------------------------------------
    // sequencer actions
    // ------------------------------------------------------------
    task automatic press(input int idx, input int len);
        @(negedge clk_i);
        pins_o[idx] = 1'b1;
        repeat (len) @(posedge clk_i);
        @(negedge clk_i);
        pins_o[idx] = 1'b0;
    endtask
    task automatic wait_for(input int idx);
        int n;
        n = 0;
        while (status_i[idx] !== 1'b1 && n < 50)
        begin
            @(negedge clk_i);
            n++;
        end
        if (n == 50)
            late_o = 1'b1;
    endtask
    task automatic select_prog(input logic [rioc_pkg::PROG_WIDTH-1:0] num);
        pins_o[7:4] = num;
    endtask
    // fresh start only from reset state, number settled first
    task automatic begin_prog(input logic [rioc_pkg::PROG_WIDTH-1:0] num, input int len);
        select_prog(num);
        repeat (3) @(negedge clk_i);
        wait_for(rioc_pkg::OUT_RESET);
        press(rioc_pkg::IN_START, len);
    endtask
    // ends a running program: pause, wait for paused, then reset
    task automatic end_prog();
        press(rioc_pkg::IN_PAUSE, 3);
        wait_for(rioc_pkg::OUT_PAUSED);
        press(rioc_pkg::IN_RESET, 3);
    endtask
endmodule
`default_nettype wire

// >>> tb/remote_io_control_port_tb.sv
`timescale 1ns/1ps
`default_nettype none
module remote_io_control_port_tb;
    typedef struct packed {
        logic [3:0] pin;
        logic       stop;
        logic       done;
        logic [5:0] cmd;
        logic [3:0] st;
        logic       motor;
    } rioc_row_type;
    logic        clk_i = 1'b0;
    logic        reset_n_i = 1'b0;
    logic        clk_en_i = 1'b1;
    logic        seen_clr = 1'b0;
    logic        console_select_i = 1'b1;
    logic        teach_mode_i = 1'b0;
    logic        auto_mode_i = 1'b0;
    logic        estop_i = 1'b0;
    logic        safeguard_open_i = 1'b0;
    logic        enable_cond_i = 1'b0;
    logic        home_pos_i = 1'b0;
    logic        error_event_i = 1'b0;
    logic        error_cancel_i = 1'b0;
    logic        stopped_i = 1'b0;
    logic        done_i = 1'b0;
    logic [15:0] pins;
    logic [15:0] remote_out_o;
    logic        cmd_reset_o, cmd_start_o, cmd_resume_o, cmd_pause_o, cmd_home_o, cmd_cal_o;
    logic [3:0]  program_number_command_o;
    logic        motor_power_o;
    logic        seq_late;
    logic [5:0]  cmd_now;
    logic [5:0]  cmd_seen = 6'h00;
    int          n_pulse = 0;
    int          n_base = 0;
    int          cycles = 0;
    int          error_cnt = 0;
    int          n_compared = 0;
    // {reset, start, resume, pause, home, cal}
    rioc_row_type rows [11] = '{
        {4'h2, 1'h0, 1'h0, 6'h10, 4'h4, 1'h0}, {4'h1, 1'h0, 1'h0, 6'h04, 4'h4, 1'h0},
        {4'h2, 1'h1, 1'h0, 6'h08, 4'h4, 1'h0}, {4'h1, 1'h1, 1'h0, 6'h04, 4'h2, 1'h0},
        {4'h0, 1'h1, 1'h0, 6'h20, 4'h1, 1'h0}, {4'h3, 1'h0, 1'h0, 6'h02, 4'h4, 1'h0},
        {4'h8, 1'h0, 1'h1, 6'h01, 4'hc, 1'h0}, {4'h9, 1'h0, 1'h1, 6'h00, 4'h1, 1'h1},
        {4'ha, 1'h0, 1'h0, 6'h00, 4'h1, 1'h0}, {4'h1, 1'h0, 1'h0, 6'h00, 4'h1, 1'h0},
        {4'hb, 1'h0, 1'h0, 6'h00, 4'h1, 1'h0}};
    assign cmd_now = {cmd_reset_o, cmd_start_o, cmd_resume_o, cmd_pause_o, cmd_home_o, cmd_cal_o};
    always #10 clk_i = ~clk_i;
    rioc_port rioc_port_i (.clk_i(clk_i), .reset_n_i(reset_n_i), .clk_en_i(clk_en_i), .remote_in_i(pins),
        .console_select_i(console_select_i), .teach_mode_i(teach_mode_i), .auto_mode_i(auto_mode_i),
        .estop_i(estop_i), .safeguard_open_i(safeguard_open_i), .enable_cond_i(enable_cond_i),
        .home_pos_i(home_pos_i), .error_event_i(error_event_i), .error_cancel_i(error_cancel_i),
        .stopped_i(stopped_i), .done_i(done_i), .remote_out_o(remote_out_o), .cmd_reset_o(cmd_reset_o),
        .cmd_start_o(cmd_start_o), .cmd_resume_o(cmd_resume_o), .cmd_pause_o(cmd_pause_o),
        .cmd_home_o(cmd_home_o), .cmd_cal_o(cmd_cal_o), .program_number_command_o(program_number_command_o),
        .motor_power_o(motor_power_o));
    rioc_seq_model rioc_seq_model_i (.clk_i(clk_i), .status_i(remote_out_o), .pins_o(pins), .late_o(seq_late));
    // ------------------------------------------------------------
    // checking helpers
    // ------------------------------------------------------------
    task automatic chk(input logic c, input string msg);
        n_compared++;
        if (c !== 1'b1)
        begin
            $display("BAD t=%0t %s", $time, msg);
            error_cnt++;
        end
    endtask
    task automatic conclude();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic step(input int idx, input int len);
        seen_clr = 1'b1;
        @(negedge clk_i);
        seen_clr = 1'b0;
        rioc_seq_model_i.press(idx, len);
        repeat (2) @(negedge clk_i);
    endtask
    always @(posedge clk_i)
    begin
        cmd_seen <= seen_clr ? 6'h00 : (cmd_seen | cmd_now);
        n_pulse <= n_pulse + int'(cmd_start_o === 1'b1);
        cycles <= cycles + 1;
        if (cycles == 3000)
        begin
            error_cnt++;
            conclude();
        end
    end
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (4) @(negedge clk_i);
        chk(remote_out_o === 16'h0000 && cmd_now === 6'h00, "outputs during reset");
        @(negedge clk_i);
        reset_n_i = 1'b1;
        rioc_seq_model_i.select_prog(4'ha);
        repeat (3) @(negedge clk_i);
        chk(remote_out_o[0] === 1'b1 && remote_out_o[2:1] === 2'h0, "reset state after release");
        $display("reset test done");
        for (int i = 0; i < 11; i++)
        begin
            stopped_i = rows[i].stop;
            done_i = rows[i].done;
            repeat (2) @(negedge clk_i);
            done_i = 1'b0;
            step(int'(rows[i].pin), 3);
            chk(cmd_seen === rows[i].cmd, "command pulse");
            chk({remote_out_o[8], remote_out_o[2:0]} === rows[i].st, "state outputs");
            chk(motor_power_o === rows[i].motor && remote_out_o[9] === rows[i].motor, "motor");
            if (rows[i].cmd == 6'h10)
                chk(program_number_command_o === 4'ha && remote_out_o[7:4] === 4'ha, "program a");
        end
        $display("row test done");
        n_base = n_pulse;
        stopped_i = 1'b0;
        rioc_seq_model_i.begin_prog(4'h5, 12);
        repeat (4) @(negedge clk_i);
        chk(n_pulse - n_base === 1, "held start acts once");
        chk(program_number_command_o === 4'h5 && remote_out_o[7:4] === 4'h5, "program 5");
        $display("held input test done");
        error_event_i = 1'b1;
        @(negedge clk_i);
        error_event_i = 1'b0;
        repeat (3) @(negedge clk_i);
        chk(remote_out_o[10] === 1'b1, "error shown");
        step(rioc_pkg::IN_RESET, 3);
        chk(remote_out_o[10] === 1'b1 && remote_out_o[2:0] === 3'h1, "error kept, program ended");
        error_cancel_i = 1'b1;
        stopped_i = 1'b1;
        rioc_seq_model_i.begin_prog(4'h5, 3);
        rioc_seq_model_i.end_prog();
        repeat (3) @(negedge clk_i);
        chk(remote_out_o[10] === 1'b0 && remote_out_o[2:0] === 3'h1, "error cleared by reset");
        $display("error test done");
        {estop_i, safeguard_open_i, auto_mode_i, enable_cond_i, home_pos_i} = 5'h1f;
        for (int j = 0; j < 2; j++)
        begin
            teach_mode_i = 1'(j == 0);
            console_select_i = 1'(j == 0);
            step(rioc_pkg::IN_START, 3);
            chk(cmd_seen === 6'h00 && remote_out_o[0] === 1'b1, "start ignored");
            chk(remote_out_o[15:11] === {1'h1, teach_mode_i, 3'h7} && remote_out_o[3] === 1'b1, "mirrors");
        end
        chk(seq_late === 1'b0, "sequencer wait");
        $display("mode test done");
        clk_en_i = 1'b0;
        home_pos_i = 1'b0;
        repeat (3) @(negedge clk_i);
        chk(remote_out_o[3] === 1'b1, "outputs frozen while disabled");
        clk_en_i = 1'b1;
        repeat (2) @(negedge clk_i);
        chk(remote_out_o[3] === 1'b0, "outputs follow again when enabled");
        $display("enable test done");
        conclude();
    end
endmodule
`default_nettype wire
